// File: pagpio_pkg.sv
// package: register map, field positions and carriers for port A logic
package pagpio_pkg;

	// vector laid out by pin number: five pads, position 2 vacant
	localparam int          PA_W           = 6;
	localparam int          PIN_A0         = 0;
	localparam int          PIN_A1         = 1;
	localparam int          PIN_VOID       = 2;
	localparam int          PIN_A3         = 3;
	localparam int          PIN_A4         = 4;
	localparam int          PIN_A5         = 5;
	localparam logic [2:0]  OFS_PINVAL     = 3'h0;
	localparam logic [2:0]  OFS_DIR        = 3'h1;
	localparam logic [2:0]  OFS_LATCH      = 3'h2;
	localparam logic [2:0]  OFS_ANSEL      = 3'h3;
	localparam logic [2:0]  OFS_STEER      = 3'h4;
	localparam logic [2:0]  OFS_MISC       = 3'h5;

	localparam int          STEER_REFERENCE_CLOCK_OUTPUT     = 7;
	localparam int          STEER_SDO      = 6;
	localparam int          STEER_SS       = 5;
	localparam int          STEER_TGATE    = 3;
	localparam int          STEER_PWM      = 2;
	localparam logic [7:0]  STEER_MASK     = 8'hEC;
	localparam logic [7:0]  STEER_RST      = 8'h00;

	// pins a0, a1, a3 are input only; a2 does not exist
	localparam logic [5:0]  DIR_FIXED_ONE  = 6'h0B;
	localparam logic [5:0]  DIR_WR_MASK    = 6'h30;
	localparam logic [5:0]  DIR_RST        = 6'h3B;
	localparam logic [5:0]  PIN_PRESENT    = 6'h3B;
	localparam logic [5:0]  USB_PINS       = 6'h03;
	localparam logic [5:0]  ANSEL_MASK     = 6'h3B;
	localparam logic [5:0]  ANSEL_RST      = 6'h3B;
	localparam logic [5:0]  LATCH_RST      = 6'h00;
	localparam logic [5:0]  OUT_CAPABLE    = 6'h30;

	localparam int          MISC_USB_EN    = 0;
	localparam int          MISC_SMALL     = 1;
	localparam int          MISC_PIN20     = 2;
	localparam logic [7:0]  MISC_RST       = 8'h02;
	localparam logic [7:0]  MISC_MASK      = 8'h07;

	typedef struct packed {
		logic       clkout_en;
		logic       clkout;
		logic       sosco_en;
		logic       sosco;
		logic       refclk_en;
		logic       reference_clock_output;
		logic       sdo_en;
		logic       sdo;
		logic       pwm_en;
		logic       pwm_channel_two;
	} pagpio_periph_s;

	typedef struct packed {
		logic       c2_oe;
		logic       c2_out;
		logic       c3_oe;
		logic       c3_out;
	} pagpio_portc_s;

	typedef struct packed {
		logic       slave_select;
		logic       timer_gate_input;
	} pagpio_inputs_s;

endpackage

// File: pagpio_top.sv
// port A pin logic with alternate pin steering and register port
//Operation
//- steering bits never alter direction; overrides follow the selected pin
//- the unselected pin behaves as though the function were absent
//- bit 7 set puts reference clock on c3, clear on a4
//- bit 6 set puts serial out on a4, clear on c2 (small parts)
//- bit 5 set: slave select from a3; clear: c3 or c6 by package
//- bit 3 set: timer gate from a3; clear from a4
//- bit 2 set: pwm two on a5; clear on c3 (small parts)
//- five-pin port; direction one makes the pin input, driver off
//- direction zero drives the pin from the output latch
//- pins a0, a1, a3 input only; direction bits read one
//- pin value read gives pin levels; write updates the latch
//- port writes load the latch directly from the write data, masked to output-capable pins
//- direction controls drivers even on analog pins
//- analog-selected pins read zero digitally; analog functions enabled
//- analog select does not affect digital output
//- analog select resets to analog mode
//- only the highest priority enabled output controls a pin
//- analog inputs active only while analog select is set
//- peripheral outputs drive analog-mode pins with same priority
//- usb off: a0 and a1 are plain inputs, never driven
//- usb on: usb owns a0 and a1; general reads unavailable
//- latch read gives stored latch; latch write equals port write
`timescale 1ns/1ps
module pagpio_top
	import pagpio_pkg::*;
#(
	parameter int NPIN = PA_W
) (
	input  wire logic           CLK,
	input  wire logic           SYS_RST,
	input  wire logic [2:0]     ADDR,
	input  wire logic [7:0]     WDATA,
	input  wire logic           WR_STB,
	input  wire logic           RD_STB,
	output logic      [7:0]     RDATA,
	input  wire logic [NPIN-1:0] PA_IN,
	output logic      [NPIN-1:0] PA_OUT,
	output logic      [NPIN-1:0] PA_OE,
	output logic      [NPIN-1:0] PA_ANALOG_EN,
	input  wire logic           PC2_IN,
	input  wire logic           PC3_IN,
	input  wire logic           PC6_IN,
	output pagpio_portc_s       PORTC_OVR,
	input  pagpio_periph_s      PERIPH,
	output pagpio_inputs_s      PERIPH_IN,
	output logic                USB_ENABLED
);

	// vector is laid out by pin number, a2 position vacant
	if (NPIN != PA_W) begin : g_npin_bad
		$error("port A vector must match the pin layout");
	end

	// ***********************************************************
	// registers
	// ***********************************************************
	logic [NPIN-1:0] dir_reg;
	logic [NPIN-1:0] latch_reg;
	logic [NPIN-1:0] ansel_reg;
	logic [7:0]      steer_reg;
	logic [7:0]      misc_reg;
	logic [NPIN-1:0] pin_rd;
	logic [7:0]      rdata_next;
	logic            usb_en;
	logic            small_pkg;

	assign usb_en    = misc_reg[MISC_USB_EN];
	assign small_pkg = misc_reg[MISC_SMALL];
	assign USB_ENABLED = usb_en;

	// write strobes to port and latch both land here
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			latch_reg <= LATCH_RST;
		end else if (WR_STB && (ADDR == OFS_PINVAL
			|| ADDR == OFS_LATCH)) begin
			latch_reg <= WDATA[NPIN-1:0] & OUT_CAPABLE;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			dir_reg <= DIR_RST;
		end else if (WR_STB && ADDR == OFS_DIR) begin
			dir_reg <= (WDATA[NPIN-1:0] & DIR_WR_MASK) | DIR_FIXED_ONE;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ansel_reg <= ANSEL_RST;
		end else if (WR_STB && ADDR == OFS_ANSEL) begin
			ansel_reg <= WDATA[NPIN-1:0] & ANSEL_MASK;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			steer_reg <= STEER_RST;
		end else if (WR_STB && ADDR == OFS_STEER) begin
			steer_reg <= WDATA & STEER_MASK;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			misc_reg <= MISC_RST;
		end else if (WR_STB && ADDR == OFS_MISC) begin
			misc_reg <= WDATA & MISC_MASK;
		end
	end

	// ***********************************************************
	// pin input path
	// ***********************************************************
	// analog pins read zero
	// usb pins unreadable while usb owns them
	// a2 has no pad, so its position always reads zero
	always_comb begin
		pin_rd = PA_IN & ~ansel_reg & PIN_PRESENT;
		if (usb_en)
			pin_rd = pin_rd & ~USB_PINS;
	end

	assign PA_ANALOG_EN = ansel_reg;

	always_comb begin
		PERIPH_IN.slave_select = steer_reg[STEER_SS] ? pin_rd[PIN_A3]
			: (misc_reg[MISC_PIN20] ? PC6_IN : PC3_IN);
		PERIPH_IN.timer_gate_input = steer_reg[STEER_TGATE]
			? pin_rd[PIN_A3] : pin_rd[PIN_A4];
	end

	// ***********************************************************
	// output priority
	// ***********************************************************
	logic reference_clock_output_a4, sdo_a4, pwm_a5, reference_clock_output_c3, sdo_c2, pwm_c3;

	assign reference_clock_output_a4 = PERIPH.refclk_en && !steer_reg[STEER_REFERENCE_CLOCK_OUTPUT];
	assign reference_clock_output_c3 = PERIPH.refclk_en && steer_reg[STEER_REFERENCE_CLOCK_OUTPUT];
	assign sdo_a4  = PERIPH.sdo_en && small_pkg && steer_reg[STEER_SDO];
	assign sdo_c2  = PERIPH.sdo_en && !(small_pkg && steer_reg[STEER_SDO]);
	assign pwm_a5  = PERIPH.pwm_en && small_pkg && steer_reg[STEER_PWM];
	assign pwm_c3  = PERIPH.pwm_en && !(small_pkg && steer_reg[STEER_PWM]);

	// same chain regardless of analog mode
	// analog select not in output path
	always_comb begin
		PA_OUT = latch_reg;
		PA_OE  = '0;
		PA_OE[PIN_A4] = !dir_reg[PIN_A4];
		PA_OE[PIN_A5] = !dir_reg[PIN_A5];
		if (PERIPH.clkout_en)
			PA_OUT[PIN_A4] = PERIPH.clkout;
		else if (PERIPH.sosco_en)
			PA_OUT[PIN_A4] = PERIPH.sosco;
		else if (reference_clock_output_a4)
			PA_OUT[PIN_A4] = PERIPH.reference_clock_output;
		else if (sdo_a4)
			PA_OUT[PIN_A4] = PERIPH.sdo;
		if (pwm_a5)
			PA_OUT[PIN_A5] = PERIPH.pwm_channel_two;
		// a0, a1 never driven by port
		// input-only and vacant positions stay quiet
		PA_OUT[PIN_A0] = 1'b0;
		PA_OUT[PIN_A1] = 1'b0;
		PA_OUT[PIN_VOID] = 1'b0;
		PA_OUT[PIN_A3] = 1'b0;
	end

	always_comb begin
		PORTC_OVR.c2_oe  = sdo_c2;
		PORTC_OVR.c2_out = PERIPH.sdo;
		PORTC_OVR.c3_oe  = reference_clock_output_c3 || pwm_c3;
		PORTC_OVR.c3_out = reference_clock_output_c3 ? PERIPH.reference_clock_output
			: PERIPH.pwm_channel_two;
	end

	// ***********************************************************
	// register read port
	// ***********************************************************
	always_comb begin
		rdata_next = 8'h00;
		unique case (ADDR)
			OFS_PINVAL: rdata_next[NPIN-1:0] = pin_rd;
			OFS_DIR:    rdata_next[NPIN-1:0] = dir_reg;
			OFS_LATCH:  rdata_next[NPIN-1:0] = latch_reg;
			OFS_ANSEL:  rdata_next[NPIN-1:0] = ansel_reg;
			OFS_STEER:  rdata_next = steer_reg;
			OFS_MISC:   rdata_next = misc_reg;
			default:    rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST)
			RDATA <= 8'h00;
		else if (RD_STB)
			RDATA <= rdata_next;
		else
			RDATA <= 8'h00;
	end


	// ***********************************************************
	// checks
	// ***********************************************************
	property p_dir_fixed;
		@(posedge CLK) disable iff (SYS_RST)
		(dir_reg & DIR_FIXED_ONE) == DIR_FIXED_ONE;
	endproperty
	a_dir_fixed: assert property (p_dir_fixed)
		else $error("fixed direction bits not one");

	property p_rmw;
		@(posedge CLK) disable iff (SYS_RST)
		WR_STB && ADDR == OFS_LATCH |=>
			latch_reg == ($past(WDATA[NPIN-1:0]) & OUT_CAPABLE);
	endproperty
	a_rmw: assert property (p_rmw)
		else $error("latch write lost");

	property p_analog_zero;
		@(posedge CLK) disable iff (SYS_RST)
		RD_STB && ADDR == OFS_PINVAL |=>
			(RDATA[NPIN-1:0] & $past(ansel_reg)) == '0;
	endproperty
	a_analog_zero: assert property (p_analog_zero)
		else $error("analog pin read nonzero");

	property p_usb_pins;
		@(posedge CLK) disable iff (SYS_RST)
		PA_OE[1:0] == 2'b00;
	endproperty
	a_usb_pins: assert property (p_usb_pins)
		else $error("a0 or a1 driven by port");

	property p_a4_drive;
		@(posedge CLK) disable iff (SYS_RST)
		!dir_reg[4] && !PERIPH.clkout_en && !PERIPH.sosco_en
			&& !reference_clock_output_a4 && !sdo_a4 |-> PA_OE[4] && PA_OUT[4] == latch_reg[4];
	endproperty
	a_a4_drive: assert property (p_a4_drive)
		else $error("a4 not driving latch");

	property p_a4_off;
		@(posedge CLK) disable iff (SYS_RST)
		dir_reg[PIN_A4] |-> !PA_OE[PIN_A4];
	endproperty
	a_a4_off: assert property (p_a4_off)
		else $error("a4 driven as input");

	property p_reference_clock_output_route;
		@(posedge CLK) disable iff (SYS_RST)
		PERIPH.refclk_en && steer_reg[STEER_REFERENCE_CLOCK_OUTPUT] |->
			PORTC_OVR.c3_oe && !reference_clock_output_a4
			&& PORTC_OVR.c3_out == PERIPH.reference_clock_output;
	endproperty
	a_reference_clock_output_route: assert property (p_reference_clock_output_route)
		else $error("reference clock misrouted");

	property p_ansel_rst;
		@(posedge CLK) $fell(SYS_RST) |-> ansel_reg == ANSEL_RST;
	endproperty
	a_ansel_rst: assert property (p_ansel_rst)
		else $error("analog select not reset to analog");

	property p_a5_drive;
		@(posedge CLK) disable iff (SYS_RST)
		!dir_reg[PIN_A5] && !pwm_a5 |->
			PA_OE[PIN_A5] && PA_OUT[PIN_A5] == latch_reg[PIN_A5];
	endproperty
	a_a5_drive: assert property (p_a5_drive)
		else $error("a5 not driving latch");

	property p_a5_off;
		@(posedge CLK) disable iff (SYS_RST)
		dir_reg[PIN_A5] |-> !PA_OE[PIN_A5];
	endproperty
	a_a5_off: assert property (p_a5_off)
		else $error("a5 driven as input");

	property p_pwm_a5;
		@(posedge CLK) disable iff (SYS_RST)
		PERIPH.pwm_en && small_pkg && steer_reg[STEER_PWM] |->
			PA_OUT[PIN_A5] == PERIPH.pwm_channel_two && !pwm_c3;
	endproperty
	a_pwm_a5: assert property (p_pwm_a5)
		else $error("pwm two not on a5");

	property p_input_only;
		@(posedge CLK) disable iff (SYS_RST)
		!PA_OE[PIN_A3] && !PA_OE[PIN_VOID];
	endproperty
	a_input_only: assert property (p_input_only)
		else $error("input-only pin driven");

	property p_usb_read;
		@(posedge CLK) disable iff (SYS_RST)
		RD_STB && ADDR == OFS_PINVAL && usb_en |=>
			(RDATA[NPIN-1:0] & USB_PINS) == '0;
	endproperty
	a_usb_read: assert property (p_usb_read)
		else $error("usb pins readable");

	property p_pin_read;
		@(posedge CLK) disable iff (SYS_RST)
		RD_STB && ADDR == OFS_PINVAL && !usb_en |=> RDATA[NPIN-1:0]
			== ($past(PA_IN) & ~$past(ansel_reg) & PIN_PRESENT);
	endproperty
	a_pin_read: assert property (p_pin_read)
		else $error("pin value read wrong");

	property p_latch_read;
		@(posedge CLK) disable iff (SYS_RST)
		RD_STB && ADDR == OFS_LATCH |=>
			RDATA[NPIN-1:0] == $past(latch_reg);
	endproperty
	a_latch_read: assert property (p_latch_read)
		else $error("latch read wrong");

	property p_port_write;
		@(posedge CLK) disable iff (SYS_RST)
		WR_STB && ADDR == OFS_PINVAL |=>
			latch_reg == ($past(WDATA[NPIN-1:0]) & OUT_CAPABLE);
	endproperty
	a_port_write: assert property (p_port_write)
		else $error("port write lost");

	property p_steer_dir;
		@(posedge CLK) disable iff (SYS_RST)
		WR_STB && ADDR == OFS_STEER |=>
			dir_reg == $past(dir_reg);
	endproperty
	a_steer_dir: assert property (p_steer_dir)
		else $error("steering changed direction");

	property p_sdo_a4;
		@(posedge CLK) disable iff (SYS_RST)
		PERIPH.sdo_en && small_pkg && steer_reg[STEER_SDO]
			&& !PERIPH.clkout_en && !PERIPH.sosco_en && !reference_clock_output_a4
			|-> PA_OUT[PIN_A4] == PERIPH.sdo && !PORTC_OVR.c2_oe;
	endproperty
	a_sdo_a4: assert property (p_sdo_a4)
		else $error("serial out misrouted");

	property p_ss_c6;
		@(posedge CLK) disable iff (SYS_RST)
		!steer_reg[STEER_SS] && misc_reg[MISC_PIN20] |->
			PERIPH_IN.slave_select == PC6_IN;
	endproperty
	a_ss_c6: assert property (p_ss_c6)
		else $error("slave select source wrong");

	property p_clkout_first;
		@(posedge CLK) disable iff (SYS_RST)
		PERIPH.clkout_en |-> PA_OUT[PIN_A4] == PERIPH.clkout;
	endproperty
	a_clkout_first: assert property (p_clkout_first)
		else $error("a4 priority broken");

endmodule

// File: pagpio_pin_model.sv
// external pin model for port A: resolves driven and released pins
`timescale 1ns/1ps
module pagpio_pin_model
	import pagpio_pkg::*;
(
	input  wire logic [PA_W-1:0] PA_OUT,
	input  wire logic [PA_W-1:0] PA_OE,
	input  wire logic [PA_W-1:0] EXT_LVL,
	output logic      [PA_W-1:0] PA_IN
);
	always_comb begin
		for (int i = 0; i < PA_W; i++) begin
			PA_IN[i] = PA_OE[i] ? PA_OUT[i] : EXT_LVL[i];
		end
	end
endmodule

// File: tb.sv
// self-checking bench for port A pin logic
`timescale 1ns/1ps
module tb
	import pagpio_pkg::*;
;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic [2:0]        addr = 3'h0;
	logic [7:0]        wdata = 8'h00;
	logic              wr = 1'b0;
	logic              rd = 1'b0;
	logic [7:0]        rdata;
	logic [PA_W-1:0]   pa_in;
	logic [PA_W-1:0]   pa_out;
	logic [PA_W-1:0]   pa_oe;
	logic [PA_W-1:0]   pa_an;
	logic [PA_W-1:0]   ext = 6'h3F;
	logic              pc3 = 1'b0;
	logic              pc6 = 1'b1;
	pagpio_portc_s     pc_ovr;
	pagpio_periph_s    per = '0;
	pagpio_inputs_s    pin_in;
	logic              usb_on;
	logic [7:0]        exp_q[$];
	logic              rd_d = 1'b0;
	int                err_total = 0;
	int                n_tests = 0;
	logic [7:0]        v;

	always #50 clk = ~clk;

	pagpio_top dut_u (.CLK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata),
		.WR_STB(wr), .RD_STB(rd), .RDATA(rdata), .PA_IN(pa_in),
		.PA_OUT(pa_out), .PA_OE(pa_oe), .PA_ANALOG_EN(pa_an),
		.PC2_IN(1'b0), .PC3_IN(pc3), .PC6_IN(pc6), .PORTC_OVR(pc_ovr),
		.PERIPH(per), .PERIPH_IN(pin_in), .USB_ENABLED(usb_on));

	pagpio_pin_model pins_u (.PA_OUT(pa_out), .PA_OE(pa_oe),
		.EXT_LVL(ext), .PA_IN(pa_in));

	// ****************************************
	// compare and bus tasks
	// ****************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		n_tests++;
		if (seen !== want) begin
			err_total++;
			$display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask

	// expectation queued now, judged by the monitor two edges on
	task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
	endtask

	// a4 driver, port C overrides, a1/a0 drivers packed in one byte
	task automatic look(input logic [7:0] want, input logic [7:0] m);
		@(negedge clk);
		check({pa_oe[4], pa_out[4], pc_ovr, pa_oe[1:0]} & m, want);
		@(posedge clk);
	endtask

	// a5 driver and value, sampled mid-cycle like look
	task automatic look5(input logic [1:0] want);
		@(negedge clk);
		check({6'h0, pa_oe[5], pa_out[5]}, {6'h0, want});
		@(posedge clk);
	endtask

	always @(posedge clk) begin
		rd_d <= rd;
		if (rd_d && exp_q.size() > 0) begin
			check(rdata, exp_q.pop_front());
		end
	end

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		v = $urandom(32'h469e);
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check({2'h0, pa_an}, {2'h0, ANSEL_RST});
		rd_reg(OFS_STEER, 8'h00);
		rd_reg(OFS_DIR, 8'h3B);
		rd_reg(OFS_PINVAL, 8'h00);
		rd_reg(3'h7, 8'h00);
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			v = $urandom();
			wr_reg(OFS_STEER, v);
			rd_reg(OFS_STEER, v & STEER_MASK);
		end
		wr_reg(OFS_DIR, 8'h00);
		rd_reg(OFS_DIR, 8'h0B);
		wr_reg(OFS_STEER, 8'hEC);
		rd_reg(OFS_DIR, 8'h0B);
		wr_reg(OFS_LATCH, 8'hFF);
		rd_reg(OFS_LATCH, 8'h30);
		wr_reg(OFS_PINVAL, 8'h10);
		rd_reg(OFS_LATCH, 8'h10);
		$display("register test done");
		// pins still analog here: outputs must not care
		look(8'hC0, 8'hFF);
		look5(2'b10);
		per <= '{sdo_en: 1'b1, refclk_en: 1'b1, reference_clock_output: 1'b1,
			pwm_en: 1'b1, pwm_channel_two: 1'b1, default: 1'b0};
		look(8'h8C, 8'hFF);
		look5(2'b11);
		wr_reg(OFS_STEER, 8'h00);
		look(8'hEC, 8'hFF);
		look5(2'b10);
		per.clkout_en <= 1'b1;
		look(8'hAC, 8'hFF);
		per <= '0;
		wr_reg(OFS_DIR, 8'hFF);
		look(8'h00, 8'hBF);
		look5(2'b00);
		$display("output test done");
		wr_reg(OFS_ANSEL, 8'h00);
		v = $urandom();
		ext <= v[5:0];
		pc3 <= v[6];
		pc6 <= ~v[6];
		wr_reg(OFS_STEER, 8'h28);
		check({6'h0, pin_in}, {6'h0, v[3], v[3]});
		wr_reg(OFS_STEER, 8'h00);
		check({6'h0, pin_in}, {6'h0, v[6], v[4]});
		wr_reg(OFS_MISC, 8'h06);
		check({6'h0, pin_in}, {6'h0, ~v[6], v[4]});
		rd_reg(OFS_PINVAL, {2'h0, v[5:3], 1'b0, v[1:0]});
		wr_reg(OFS_MISC, 8'h03);
		check({7'h0, usb_on}, 8'h01);
		rd_reg(OFS_PINVAL, {2'h0, v[5:3], 3'h0});
		repeat (3) @(posedge clk);
		$display("input test done");
		complete_run();
	end

	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		complete_run();
	end
endmodule
